// ---- hdl/ued_top.sv ----
// endpoint buffer descriptor engine with register bus and packet memory
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ued_top (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [10:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic TOK_VALID,
	input wire ued_pkg::ued_tok_t TOK,
	output logic TOK_READY,
	input wire logic RX_VALID,
	input wire ued_pkg::ued_byte_t RX_BYTE,
	output logic RX_READY,
	output logic TX_VALID,
	output ued_pkg::ued_byte_t TX_BYTE,
	input wire logic TX_READY,
	output logic HS_VALID,
	output ued_pkg::ued_hs_t HS_CODE
);
	import ued_pkg::*;
	typedef enum logic [3:0] {E_IDLE = 4'h0, E_RDA = 4'h1, E_RDC = 4'h2, E_GO = 4'h3,
		E_TXRD = 4'h4, E_TXCAP = 4'h5, E_TXB = 4'h6, E_RX = 4'h7, E_RXWR = 4'h8,
		E_FIN = 4'h9} ued_eng_t;
	ued_eng_t st_q; // engine state
	ued_tok_t tok_q; // token being served
	logic [15:0] ctl_q [NEP]; // endpoint control words
	logic [NEP-1:0] bsel_q; // double buffer selector per endpoint
	logic [12:0] tbase_q; // table base, byte address bits 15:3
	logic ovf_seen_q; // sticky overflow status
	logic [14:0] baddr_q; // buffer halfword pointer
	logic [15:0] cnt_ent_q; // fetched count entry
	logic [15:0] word_q; // halfword being built or sent
	logic [9:0] tally_q; // bytes moved so far
	logic hi_q; // high byte lane next
	logic ovf_q, lastw_q, drop_q, pair_q, dbl_q, iso_q, sout_q;
	logic hs_en_q; // refused OUT owes a handshake
	ued_hs_t hs_pend_q; // handshake owed by a refused OUT
	logic hs_valid_q;
	ued_hs_t hs_code_q;
	logic ack_q, memsel_q; // bus answer pending, answer from memory
	logic [31:0] rd_q; // register read data
	logic [15:0] t_ctl; // control word of incoming token
	logic t_in, t_dbl;
	logic [1:0] t_st, t_ty;
	logic [10:0] cap; // receive capacity in bytes
	logic [MEM_AW-1:0] tb_hw; // table base as halfword index
	logic eng_en, eng_we, cpu_go, in_mem, req, wr_ctl, rx_ok, tok_take;
	logic [MEM_AW-1:0] eng_addr, mem_addr;
	logic [15:0] eng_wd, mem_rd, wd;
	logic f_valid, f_ready, tx_last, store;
	ued_byte_t f_byte;
	logic [2:0] cpu_ep;

	// incoming byte queue, stalls the host side when full
	ued_fifo #(.W($bits(ued_byte_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK_SYS),
		.rst(RST),
		.in_valid(RX_VALID),
		.in_ready(RX_READY),
		.in_data(RX_BYTE),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_byte)
	);
	// packet memory shared with software
	ued_mem #(.W(16), .AW(MEM_AW)) u_mem (
		.clk(CLK_SYS),
		.rst(RST),
		.en(eng_en || (cpu_go && in_mem)),
		.we(eng_en ? eng_we : (AVS_WRITE && (&AVS_BYTEENABLE[1:0]))),
		.addr(mem_addr),
		.wdata(eng_en ? eng_wd : wd),
		.rdata_q(mem_rd)
	);

	// token decode against the addressed endpoint
	assign t_ctl = ctl_q[TOK.ep];
	assign t_in = TOK.pid == PID_IN;
	assign t_st = t_in ? t_ctl[F_TXS+:2] : t_ctl[F_RXS+:2];
	assign t_ty = t_ctl[F_TYPE+:2];
	assign t_dbl = (t_ty == TY_BULK && t_ctl[F_KIND]) || t_ty == TY_ISO;
	assign TOK_READY = st_q == E_IDLE;
	assign tok_take = TOK_VALID && TOK_READY;
	assign tb_hw = MEM_AW'({tbase_q, 2'b00});
	assign f_ready = st_q == E_RX;
	assign tx_last = (tally_q + 10'h001) == cnt_ent_q[9:0];
	assign store = {1'b0, tally_q} < cap;
	assign rx_ok = tok_q.pid != PID_IN && !drop_q && !ovf_q;
	assign HS_VALID = hs_valid_q;
	assign HS_CODE = hs_code_q;
	assign TX_VALID = st_q == E_TXB;
	assign TX_BYTE = '{last: tx_last, data: hi_q ? word_q[15:8] : word_q[7:0]};

	// receive capacity; forbidden or reserved counts give none
	always_comb
	begin
		if (cnt_ent_q[F_GRAN])
			cap = (cnt_ent_q[F_BLK+:5] >= BLK_RSV) ? '0 :
				(11'(cnt_ent_q[F_BLK+:5]) + 11'h001) << SH_LARGE;
		else
			cap = 11'(cnt_ent_q[F_BLK+:5]) << SH_SMALL;
	end

	// engine side of the memory port; engine always wins arbitration
	always_comb
	begin
		eng_en = 1'b0;
		eng_we = 1'b0;
		eng_addr = baddr_q[MEM_AW-1:0];
		eng_wd = word_q;
		case (st_q)
		E_RDA:
		begin
			eng_en = 1'b1;
			eng_addr = tb_hw + MEM_AW'({tok_q.ep, pair_q, ENT_ADDR});
		end
		E_RDC:
		begin
			eng_en = 1'b1;
			eng_addr = tb_hw + MEM_AW'({tok_q.ep, pair_q, ENT_CNT});
		end
		E_TXRD: eng_en = 1'b1;
		E_RXWR:
		begin
			eng_en = 1'b1;
			eng_we = 1'b1;
		end
		E_FIN:
		begin
			eng_en = rx_ok;
			eng_we = 1'b1;
			eng_addr = tb_hw + MEM_AW'({tok_q.ep, pair_q, ENT_CNT});
			eng_wd = {cnt_ent_q[15:10], tally_q};
		end
		default: eng_en = 1'b0;
		endcase
	end
	assign mem_addr = eng_en ? eng_addr : AVS_ADDRESS[MEM_AW+1:2];

	// engine sequencing
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			st_q <= E_IDLE;
		else
		begin
			case (st_q)
			E_IDLE:
			begin
				// refused or disabled IN tokens leave the engine idle
				if (tok_take && t_st == ST_VALID)
					st_q <= E_RDA;
				else if (tok_take && !t_in)
					st_q <= E_RX; // refused data still drained
			end
			E_RDA: st_q <= E_RDC;
			E_RDC: st_q <= E_GO;
			E_GO:
			begin
				if (tok_q.pid != PID_IN)
					st_q <= E_RX;
				else if (mem_rd[9:0] == 10'h000)
					st_q <= E_FIN; // zero-length data packet
				else
					st_q <= E_TXRD;
			end
			E_TXRD: st_q <= E_TXCAP;
			E_TXCAP: st_q <= E_TXB;
			E_TXB:
			begin
				if (TX_READY && tx_last)
					st_q <= E_FIN;
				else if (TX_READY && hi_q)
					st_q <= E_TXRD;
			end
			E_RX:
			begin
				if (f_valid && !drop_q && store && (hi_q || f_byte.last))
					st_q <= E_RXWR;
				else if (f_valid && f_byte.last)
					st_q <= E_FIN;
			end
			E_RXWR: st_q <= lastw_q ? E_FIN : E_RX;
			E_FIN: st_q <= E_IDLE;
			default: st_q <= E_IDLE;
			endcase
		end
	end

	// token capture and buffer pair choice
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			tok_q <= '{pid: PID_NONE, ep: 3'h0};
			drop_q <= 1'b0;
			pair_q <= 1'b0;
			dbl_q <= 1'b0;
			iso_q <= 1'b0;
			sout_q <= 1'b0;
			hs_en_q <= 1'b0;
			hs_pend_q <= HS_NONE;
		end
		else if (tok_take)
		begin
			tok_q <= TOK;
			drop_q <= t_st != ST_VALID;
			dbl_q <= t_dbl;
			iso_q <= t_ty == TY_ISO;
			// status-out only for control endpoints
			sout_q <= t_ty == TY_CTRL && t_ctl[F_KIND] && TOK.pid == PID_OUT;
			// idle direction's pair reused when double buffered
			pair_q <= t_dbl ? bsel_q[TOK.ep] : !t_in;
			hs_en_q <= t_st == ST_STALL || t_st == ST_NAK;
			hs_pend_q <= (t_st == ST_STALL) ? HS_STALL : HS_NAK;
		end
	end

	// buffer pointer, byte lanes and tallies
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			baddr_q <= '0;
			cnt_ent_q <= '0;
			word_q <= '0;
			tally_q <= '0;
			hi_q <= 1'b0;
			ovf_q <= 1'b0;
			lastw_q <= 1'b0;
		end
		else
		begin
			case (st_q)
			E_RDC: baddr_q <= mem_rd[15:1]; // bit 0 ignored
			E_GO:
			begin
				cnt_ent_q <= mem_rd;
				tally_q <= '0;
				hi_q <= 1'b0;
				ovf_q <= 1'b0;
				lastw_q <= 1'b0;
			end
			E_TXCAP: word_q <= mem_rd;
			E_TXB:
			begin
				if (TX_READY) // low byte first
				begin
					tally_q <= tally_q + 10'h001;
					hi_q <= !hi_q;
					if (hi_q)
						baddr_q <= baddr_q + 15'h0001;
				end
			end
			E_RX:
			begin
				if (f_valid && !drop_q && store)
				begin
					if (hi_q)
						word_q[15:8] <= f_byte.data;
					else
						word_q <= {8'h00, f_byte.data};
					tally_q <= tally_q + 10'h001;
					hi_q <= !hi_q;
					lastw_q <= f_byte.last;
				end
				else if (f_valid && !drop_q)
					ovf_q <= 1'b1; // excess bytes dropped
			end
			E_RXWR:
			begin
				baddr_q <= baddr_q + 15'h0001;
				hi_q <= 1'b0;
			end
			default: hi_q <= hi_q;
			endcase
		end
	end

	// handshake answers; accepted iso data and overflow get none
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			hs_valid_q <= 1'b0;
			hs_code_q <= HS_NONE;
		end
		else
		begin
			hs_valid_q <= 1'b0;
			if (tok_take && t_in && (t_st == ST_STALL || t_st == ST_NAK))
			begin
				hs_valid_q <= 1'b1;
				hs_code_q <= (t_st == ST_STALL) ? HS_STALL : HS_NAK;
			end
			else if (st_q == E_FIN && tok_q.pid != PID_IN && drop_q)
			begin
				hs_valid_q <= hs_en_q; // disabled stays silent
				hs_code_q <= hs_pend_q;
			end
			else if (st_q == E_FIN && rx_ok && !iso_q)
			begin
				hs_valid_q <= 1'b1;
				hs_code_q <= (sout_q && tally_q != 10'h000) ? HS_STALL : HS_ACK;
			end
		end
	end

	// endpoint control words; hardware sets win over software clears
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < NEP; i++)
				ctl_q[i] <= '0;
			bsel_q <= '0;
		end
		else
		begin
			if (wr_ctl)
			begin
				ctl_q[cpu_ep][F_CTFR] <= ctl_q[cpu_ep][F_CTFR] & wd[F_CTFR]; // write 0 clears
				ctl_q[cpu_ep][F_CTFT] <= ctl_q[cpu_ep][F_CTFT] & wd[F_CTFT];
				ctl_q[cpu_ep][F_RXS+:2] <= ctl_q[cpu_ep][F_RXS+:2] ^ wd[F_RXS+:2];
				ctl_q[cpu_ep][F_TXS+:2] <= ctl_q[cpu_ep][F_TXS+:2] ^ wd[F_TXS+:2];
				ctl_q[cpu_ep][F_TYPE+:2] <= wd[F_TYPE+:2];
				ctl_q[cpu_ep][F_KIND] <= wd[F_KIND];
			end
			if (st_q == E_FIN && tok_q.pid == PID_IN)
			begin
				ctl_q[tok_q.ep][F_CTFT] <= 1'b1;
				if (!iso_q)
					ctl_q[tok_q.ep][F_TXS+:2] <= ST_NAK; // rearm needed per packet
				if (dbl_q)
					bsel_q[tok_q.ep] <= !bsel_q[tok_q.ep];
			end
			else if (st_q == E_FIN && rx_ok)
			begin
				ctl_q[tok_q.ep][F_CTFR] <= 1'b1;
				if (!iso_q)
					ctl_q[tok_q.ep][F_RXS+:2] <= ST_NAK;
				if (dbl_q)
					bsel_q[tok_q.ep] <= !bsel_q[tok_q.ep];
			end
		end
	end

	// bus slave: one-cycle stall, longer for memory while the engine holds the port, answer on the next edge
	assign req = AVS_READ || AVS_WRITE;
	assign in_mem = !AVS_ADDRESS[10];
	assign cpu_go = req && !ack_q && !(in_mem && eng_en);
	assign cpu_ep = AVS_ADDRESS[4:2];
	assign wd = AVS_WRITEDATA[15:0];
	assign wr_ctl = cpu_go && AVS_WRITE && AVS_ADDRESS[10:5] == A_CTL[10:5]
		&& (&AVS_BYTEENABLE[1:0]);
	assign AVS_WAITREQUEST = req && !ack_q;
	assign AVS_READDATA = memsel_q ? {16'h0000, mem_rd} : rd_q;

	// register reads, base and status writes
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			ack_q <= 1'b0;
			memsel_q <= 1'b0;
			rd_q <= '0;
			tbase_q <= '0;
			ovf_seen_q <= 1'b0;
		end
		else
		begin
			ack_q <= cpu_go;
			if (cpu_go)
				memsel_q <= in_mem;
			if (cpu_go && AVS_ADDRESS[10:5] == A_CTL[10:5])
				rd_q <= {16'h0000, ctl_q[cpu_ep]};
			else if (cpu_go && AVS_ADDRESS == A_TBASE)
				rd_q <= {16'h0000, tbase_q, 3'h0};
			else if (cpu_go && AVS_ADDRESS == A_STAT)
				rd_q <= {27'h0000000, st_q, ovf_seen_q};
			else if (cpu_go)
				rd_q <= '0; // unmapped reads zero
			if (cpu_go && AVS_WRITE && AVS_ADDRESS == A_TBASE && (&AVS_BYTEENABLE[1:0]))
				tbase_q <= AVS_WRITEDATA[15:3];
			if (st_q == E_FIN && ovf_q)
				ovf_seen_q <= 1'b1; // set wins over clear
			else if (cpu_go && AVS_WRITE && AVS_ADDRESS == A_STAT && AVS_WRITEDATA[0])
				ovf_seen_q <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	property p_tx_dis;
		tok_take && t_in && t_st == ST_DIS |=> st_q == E_IDLE && !HS_VALID;
	endproperty
	a_tx_dis: assert property (p_tx_dis) else $error("disabled IN answered");
	property p_tx_stall;
		tok_take && t_in && t_st == ST_STALL |=> HS_VALID && HS_CODE == HS_STALL;
	endproperty
	a_tx_stall: assert property (p_tx_stall) else $error("IN not stalled");
	property p_tx_valid;
		tok_take && t_in && t_st == ST_VALID |=> st_q == E_RDA ##2 st_q == E_GO;
	endproperty
	a_tx_valid: assert property (p_tx_valid) else $error("IN not served");
	property p_rx_dis;
		tok_take && !t_in && t_st == ST_DIS |=> drop_q && !hs_en_q;
	endproperty
	a_rx_dis: assert property (p_rx_dis) else $error("disabled OUT owes answer");
	property p_rx_nak;
		tok_take && !t_in && t_st == ST_NAK |=> st_q == E_RX && hs_pend_q == HS_NAK;
	endproperty
	a_rx_nak: assert property (p_rx_nak) else $error("OUT not NAKed");
	property p_pair;
		st_q == E_RDA && dbl_q |-> pair_q == bsel_q[tok_q.ep];
	endproperty
	a_pair: assert property (p_pair) else $error("wrong buffer pair");
	property p_tx_len;
		TX_VALID && TX_READY && TX_BYTE.last |=> st_q == E_FIN && tally_q == cnt_ent_q[9:0];
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("IN length wrong");
	property p_rx_cnt;
		st_q == E_FIN && rx_ok |-> eng_en && eng_we && eng_wd[9:0] == tally_q;
	endproperty
	a_rx_cnt: assert property (p_rx_cnt) else $error("count not written");
	property p_cap;
		cnt_ent_q[F_GRAN] && cnt_ent_q[F_BLK+:5] >= BLK_RSV |-> cap == 11'h000;
	endproperty
	a_cap: assert property (p_cap) else $error("reserved count has room");
	property p_ovf;
		st_q == E_RX && f_valid && !drop_q && !store |=> ovf_q && $stable(tally_q);
	endproperty
	a_ovf: assert property (p_ovf) else $error("stored past capacity");
	c_in_done: cover property (st_q == E_FIN && tok_q.pid == PID_IN);
	c_out_ack: cover property (HS_VALID && HS_CODE == HS_ACK);
	c_ovf: cover property (st_q == E_FIN && ovf_q);
	c_full: cover property (RX_VALID && !RX_READY);
endmodule
`default_nettype wire

// ---- hdl/ued_pkg.sv ----
// shared constants and types for the endpoint buffer engine
package ued_pkg;
	localparam int NEP = 8; // endpoints
	localparam int MEM_AW = 8; // packet memory halfword index bits
	localparam int FIFO_DEPTH = 4; // receive byte queue depth
	localparam logic [10:0] A_CTL = 11'h400; // endpoint controls, one word each
	localparam logic [10:0] A_TBASE = 11'h420; // descriptor table base
	localparam logic [10:0] A_STAT = 11'h424; // engine status
	localparam int F_TXS = 4; // tx handshake state, low bit
	localparam int F_CTFT = 7; // tx done flag
	localparam int F_KIND = 8; // special kind bit
	localparam int F_TYPE = 9; // endpoint type, low bit
	localparam int F_RXS = 12; // rx handshake state, low bit
	localparam int F_CTFR = 15; // rx done flag
	localparam int F_BLK = 10; // block count, low bit
	localparam int F_GRAN = 15; // block granule bit
	localparam logic [4:0] BLK_RSV = 5'h10; // first reserved count, large granule
	localparam int SH_SMALL = 1; // 2-byte granule
	localparam int SH_LARGE = 5; // 32-byte granule
	localparam logic ENT_ADDR = 1'b0; // start entry within a pair
	localparam logic ENT_CNT = 1'b1; // count entry within a pair
	typedef enum logic [1:0] {ST_DIS = 2'b00, ST_STALL = 2'b01, ST_NAK = 2'b10,
		ST_VALID = 2'b11} ued_state_t;
	typedef enum logic [1:0] {TY_BULK = 2'b00, TY_CTRL = 2'b01, TY_ISO = 2'b10,
		TY_INTR = 2'b11} ued_type_t;
	typedef enum logic [1:0] {PID_OUT = 2'b00, PID_IN = 2'b01, PID_SETUP = 2'b10,
		PID_NONE = 2'b11} ued_pid_t;
	typedef enum logic [1:0] {HS_ACK = 2'b00, HS_NAK = 2'b01, HS_STALL = 2'b10,
		HS_NONE = 2'b11} ued_hs_t;
	typedef struct packed {ued_pid_t pid; logic [2:0] ep;} ued_tok_t;
	typedef struct packed {logic last; logic [7:0] data;} ued_byte_t;
endpackage

// ---- hdl/ued_fifo.sv ----
// small first-in first-out queue with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ued_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH]; // storage
	logic [PW-1:0] wp_q, rp_q; // pointers
	logic [PW:0] n_q; // fill level
	logic push, pop;
	assign in_ready = n_q != (PW+1)'(DEPTH); // honest full
	assign out_valid = n_q != '0; // honest empty
	assign out_data = mem_q[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// storage write, no reset needed on data
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
	// pointers and level
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_q <= '0;
			rp_q <= '0;
			n_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			n_q <= n_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ---- hdl/ued_mem.sv ----
// single-port packet memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ued_mem #(
	parameter int W = 16,
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata_q
);
	logic [W-1:0] arr_q [2**AW]; // halfword store
	// write port
	always_ff @(posedge clk)
	begin
		if (en && we)
			arr_q[addr] <= wdata;
	end
	// read data held until the next enabled read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_q <= '0;
		else if (en && !we)
			rdata_q <= arr_q[addr];
	end
endmodule
`default_nettype wire

// ---- sim/ued_host.sv ----
// behavioural usb host model facing the endpoint engine's link side
`timescale 1ns/1ps
`default_nettype none
module ued_host (
	input wire logic clk,
	output logic tok_valid,
	output ued_pkg::ued_tok_t tok,
	input wire logic tok_ready,
	output logic rx_valid,
	output ued_pkg::ued_byte_t rx_byte,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire ued_pkg::ued_byte_t tx_byte,
	output logic tx_ready,
	input wire logic hs_valid,
	input wire ued_pkg::ued_hs_t hs_code
);
	import ued_pkg::*;
	ued_byte_t tx_seen[$]; // bytes taken from the device
	int hs_count; // handshakes seen so far
	ued_hs_t hs_last; // code of the latest handshake
	initial
	begin
		tok_valid = 1'b0;
		tok = '0;
		rx_valid = 1'b0;
		rx_byte = '0;
		tx_ready = 1'b0;
		hs_count = 0;
		hs_last = HS_NONE;
	end
	// a busy host: take an offered byte only every other cycle
	always @(posedge clk)
		tx_ready <= ~tx_ready;
	// collect in-data and handshakes at the sampling edge
	always @(posedge clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			tx_seen.push_back(tx_byte);
		if (hs_valid === 1'b1)
		begin
			hs_count++;
			hs_last = hs_code;
		end
	end
	// token held until the edge that takes it, then scrambled
	task automatic send_token(input ued_pid_t pid, input logic [2:0] ep, output bit ok);
		ok = 0;
		@(posedge clk);
		tok_valid <= 1'b1;
		tok <= '{pid: pid, ep: ep};
		for (int i = 0; i < 50 && !ok; i++)
		begin
			@(posedge clk);
			ok = (tok_ready === 1'b1); // ready as it stood at this edge
		end
		tok_valid <= 1'b0;
		tok <= ued_tok_t'(~tok);
	endtask
	// data packet, always closed by a byte marked last
	task automatic send_bytes(input int n, input logic [7:0] first, output bit ok);
		ok = 1;
		@(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			bit took;
			rx_valid <= 1'b1;
			rx_byte <= '{last: (i == n - 1), data: first + 8'(i)};
			took = 0;
			for (int k = 0; k < 50 && !took; k++)
			begin
				@(posedge clk);
				took = (rx_ready === 1'b1); // next byte follows at this same edge
			end
			ok = ok & took;
		end
		rx_valid <= 1'b0;
		rx_byte <= ued_byte_t'(~rx_byte); // released line shows no stale byte
	endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the endpoint buffer descriptor engine
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ued_pkg::*;
	logic clk_sys, rst; // 40 MHz clock, async reset
	logic [10:0] avs_address;
	logic avs_read, avs_write;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest;
	logic tok_valid, tok_ready, rx_valid, rx_ready, tx_valid, tx_ready, hs_valid;
	ued_tok_t tok;
	ued_byte_t rx_byte, tx_byte;
	ued_hs_t hs_code;
	int bad_count, num_checks, tbase; // tbase mirrors the table base
	ued_hs_t hs_of[4] = '{HS_NONE, HS_STALL, HS_NAK, HS_ACK}; // handshake per state
	logic [1:0] ty_of[5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b01}; // last with kind set
	ued_hs_t ty_hs[5] = '{HS_ACK, HS_ACK, HS_NONE, HS_ACK, HS_STALL};
	logic [15:0] cap_cfg[5] = '{16'h0800, 16'h0800, 16'h0000, 16'h8000, 16'hc000};
	int cap_n[5] = '{4, 5, 1, 5, 1}; // bytes sent per capacity case
	bit cap_ok[5] = '{1, 0, 0, 1, 0};
	logic [31:0] r;
	ued_top DUT (.CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .TOK_VALID(tok_valid),
		.TOK(tok), .TOK_READY(tok_ready), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
		.RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .TX_READY(tx_ready),
		.HS_VALID(hs_valid), .HS_CODE(hs_code));
	ued_host host (.clk(clk_sys), .tok_valid(tok_valid), .tok(tok), .tok_ready(tok_ready),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_byte(tx_byte), .tx_ready(tx_ready), .hs_valid(hs_valid), .hs_code(hs_code));
	// free-running system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic timeout;
		bad_count++;
		close_out();
	endtask
	// one avalon cycle: held until the rising edge that sees waitrequest low
	task automatic bus(input logic rd, input logic [10:0] a, input logic [15:0] wd,
		input logic [3:0] be, output logic [31:0] rdv);
		bit done;
		done = 0;
		rdv = 'x;
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= {16'h0, wd};
		avs_byteenable <= be;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge clk_sys);
			done = (avs_waitrequest === 1'b0); // value standing before this edge
			if (done)
				rdv = avs_readdata; // read data taken at that same edge
		end
		if (!done)
			timeout();
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a; // released lines show no stale address
	endtask
	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		logic [31:0] x;
		bus(1'b0, a, d, 4'hf, x);
	endtask
	task automatic rd(input logic [10:0] a, output logic [31:0] x);
		bus(1'b1, a, 16'h0, 4'hf, x);
	endtask
	function automatic logic [10:0] dsc(input int n, input int k);
		return 11'(4 * (tbase / 2 + n * 4 + k)); // entry k of endpoint n
	endfunction
	function automatic logic [10:0] pm(input int b);
		return 11'(2 * b); // packet byte address to bus address
	endfunction
	// software side of the control word: toggle states by writing ones, clear done flags
	task automatic set_ctl(input int n, input logic [1:0] tx, input logic [1:0] rx,
		input logic [1:0] ty, input logic kd);
		logic [31:0] x;
		rd(A_CTL + 11'(4 * n), x);
		wr(A_CTL + 11'(4 * n), {2'b00, x[13:12] ^ rx, 1'b0, ty, kd, 2'b00, x[5:4] ^ tx, 4'h0});
		rd(A_CTL + 11'(4 * n), x);
		chk("control word", x & 32'hb7b0, {18'h0, rx, 1'b0, ty, kd, 2'b00, tx, 4'h0});
	endtask
	// one token with its data, then wait for the engine to go idle
	task automatic xfer(input ued_pid_t pid, input int ep, input int nb, input ued_hs_t exp);
		int h0;
		bit ok;
		logic [31:0] x;
		h0 = host.hs_count;
		host.tx_seen.delete();
		host.send_token(pid, 3'(ep), ok);
		if (ok && pid != PID_IN)
			host.send_bytes(nb, 8'h10, ok);
		x = 32'h2;
		for (int i = 0; i < 100 && ok && x[4:1] != 4'h0; i++)
			rd(A_STAT, x);
		if (!ok || x[4:1] != 4'h0)
			timeout();
		repeat (3) @(posedge clk_sys);
		chk("handshake count", host.hs_count - h0, (exp != HS_NONE));
		if (exp != HS_NONE)
			chk("handshake code", hs_code, exp);
	endtask
	// main sequence
	initial
	begin
		rst = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = '0;
		bad_count = 0;
		num_checks = 0;
		tbase = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(A_CTL + 11'h1c, r);
		chk("control after reset", r, 32'h0);
		rd(11'h430, r);
		chk("unmapped read", r, 32'h0);
		wr(dsc(1, 0), 16'h0040);
		wr(dsc(1, 1), 16'h0003);
		bus(1'b0, dsc(1, 1), 16'h0005, 4'h1, r);
		rd(dsc(1, 1), r);
		chk("partial write ignored", r, 32'h3);
		wr(dsc(1, 2), 16'h0060);
		wr(dsc(1, 3), 16'h0800);
		wr(pm(8'h40), 16'h2211);
		wr(pm(8'h42), 16'h0033);
		for (int s = 0; s < 4; s++)
		begin
			set_ctl(1, 2'(s), ST_DIS, TY_BULK, 1'b0);
			xfer(PID_IN, 1, 0, (s == 3) ? HS_NONE : hs_of[s]);
		end
		chk("in byte total", host.tx_seen.size(), 3);
		for (int i = 0; i < host.tx_seen.size() && i < 3; i++)
			chk("in byte", host.tx_seen[i], {i == 2, 8'(8'h11 * (i + 1))});
		rd(A_CTL + 11'h4, r);
		chk("in done and nak", r & 32'h00b0, 32'h00a0);
		for (int s = 0; s < 4; s++)
		begin
			set_ctl(1, ST_DIS, 2'(s), TY_BULK, 1'b0);
			xfer(PID_OUT, 1, 3, hs_of[s]);
		end
		rd(pm(8'h60), r);
		chk("stored halfword", r, 32'h1110);
		rd(dsc(1, 3), r);
		chk("rx count entry", r, 32'h0803);
		rd(A_CTL + 11'h4, r);
		chk("out done and nak", r & 32'hb000, 32'ha000);
		wr(dsc(1, 3), 16'h8000);
		for (int t = 0; t < 5; t++)
		begin
			set_ctl(1, ST_DIS, ST_VALID, ty_of[t], t == 4);
			xfer((t == 1) ? PID_SETUP : PID_OUT, 1, 1, ty_hs[t]);
		end
		for (int c = 0; c < 5; c++)
		begin
			set_ctl(1, ST_DIS, ST_VALID, TY_BULK, 1'b0);
			wr(dsc(1, 3), cap_cfg[c]);
			wr(A_STAT, 16'h1);
			xfer(PID_OUT, 1, cap_n[c], cap_ok[c] ? HS_ACK : HS_NONE);
			rd(dsc(1, 3), r);
			chk("capacity count", r, cap_ok[c] ? cap_cfg[c] + cap_n[c] : cap_cfg[c]);
			rd(A_STAT, r);
			chk("overflow flag", r[0], !cap_ok[c]);
		end
		// bulk with kind set: first pair, then the second, in turn
		wr(dsc(1, 1), 16'h0800); // first pair becomes receive buffer 0
		wr(dsc(1, 3), 16'h0800);
		for (int b = 0; b < 2; b++)
		begin
			set_ctl(1, ST_DIS, ST_VALID, TY_BULK, 1'b1);
			xfer(PID_OUT, 1, 2 - b, HS_ACK);
			rd(dsc(1, 1 + 2 * b), r);
			chk("double buffer count", r, 32'h0802 - b);
		end
		rd(pm(8'h40), r);
		chk("double buffer data", r, 32'h1110);
		// moved table: endpoint 7 found at base plus 56
		wr(A_TBASE, 16'h0100);
		tbase = 'h100;
		rd(A_TBASE, r);
		chk("table base", r, 32'h0100);
		wr(dsc(7, 0), 16'h0080);
		wr(dsc(7, 1), 16'h0001);
		wr(pm(8'h80), 16'h0077);
		set_ctl(7, ST_VALID, ST_DIS, TY_INTR, 1'b0);
		xfer(PID_IN, 7, 0, HS_NONE);
		chk("moved in total", host.tx_seen.size(), 1);
		if (host.tx_seen.size() > 0)
			chk("moved in byte", host.tx_seen[0], 9'h177);
		close_out();
	end
endmodule
`default_nettype wire
